// File: hdl/regbank_pkg.sv
package regbank_pkg;

    // Register offsets within one channel.
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_SLOT1 = 8'h01;
    localparam logic [7:0] OFS_CEIL = 8'h02;
    localparam logic [7:0] OFS_SKIP = 8'h03;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_SWCFG = 8'h05;
    localparam logic [7:0] OFS_RAMP = 8'h06;
    localparam logic [7:0] OFS_TARGET = 8'h07;
    localparam logic [7:0] OFS_LAST = 8'h07;

    // Field positions.
    localparam int STAT_CEIL_ERR_BIT = 1;
    localparam int SKIP_SEL_LSB = 6;

    // Reset values and the skip write mask.
    localparam logic [7:0] RST_SLOT1 = 8'h00;
    localparam logic [7:0] RST_SKIP_LOW = 8'h10;
    localparam logic [7:0] SKIP_WMASK = 8'hC0;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Slave addresses of the two channels (7-bit).
    localparam logic [6:0] SLAVE_ADDR_CH0 = 7'h38;
    localparam logic [6:0] SLAVE_ADDR_CH1 = 7'h39;
    localparam int NUM_CHANNELS = 2;

    // Per-channel defaults, loaded from the programmed store after reset release.
    typedef struct packed {
        logic [7:0] ceiling;
        logic [7:0] skip;
        logic [7:0] swcfg;
        logic [7:0] ramp;
        logic [7:0] target;
        logic [7:0] comp;
    } chan_defaults_t;

    // One write request from the serial front end.
    typedef struct packed {
        logic valid;
        logic chan;
        logic [7:0] offset;
        logic [7:0] data;
    } wr_req_t;

    // Channel outputs to the regulator.
    typedef struct packed {
        logic [7:0] applied_code;
        logic ceiling_error_flag;
        logic [1:0] skip_threshold_select;
        logic [7:0] swcfg;
        logic [7:0] ramp;
        logic [7:0] comp;
    } chan_out_t;

endpackage

// File: hdl/serial_slave.sv
`timescale 1ns/100ps
// Two-wire serial slave: START/STOP detect, address match, register pointer,
// data byte, acknowledge and read shifting. Writes are issued on the rising
// data edge after the acknowledge slot, or at the STOP edge.
module serial_slave
    import regbank_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [7:0] rd_data_i,
    output regbank_pkg::wr_req_t wr_o,
    output logic [7:0] rd_ptr_o,
    output logic rd_chan_o
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_PTR = 5'b00100,
        ST_DATA = 5'b01000,
        ST_READ = 5'b10000
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic scl;
        logic sda;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic ack;
        logic chan;
        logic [7:0] ptr;
        logic pend;
        logic [7:0] pdata;
        logic [7:0] pptr;
        logic pchan;
        logic oe;
        wr_req_t wr;
    } st_t;

    st_t q, d;

    always_comb begin
        logic rise, fall, start, stop;
        rise = scl_i & ~q.scl;
        fall = ~scl_i & q.scl;
        start = scl_i & q.scl & q.sda & ~sda_i;
        stop = scl_i & q.scl & ~q.sda & sda_i;
        d = q;
        d.scl = scl_i;
        d.sda = sda_i;
        d.wr = '0;
        // A held byte is committed on the next rising data edge.
        if (q.pend && sda_i && !q.sda) begin
            d.pend = 1'b0;
            d.wr = '{valid: 1'b1, chan: q.pchan, offset: q.pptr, data: q.pdata};
        end
        if (start) begin
            d.phase = ST_ADDR;
            // The clock fall that closes a START carries no bit, so the count
            // starts one below zero and that fall brings it to zero.
            d.bitn = 4'hF;
            d.oe = 1'b0;
        end else if (stop) begin
            d.phase = ST_IDLE;
            d.oe = 1'b0;
        end else if (q.phase != ST_IDLE) begin
            if (rise && q.bitn < 4'h8) begin
                d.sh = {q.sh[6:0], sda_i};
            end
            if (fall) begin
                d.bitn = q.bitn + 4'h1;
                d.oe = 1'b0;
                if (q.bitn == 4'h7 && q.phase != ST_READ) begin
                    d.ack = 1'b1;
                    unique case (q.phase)
                        ST_ADDR: begin
                            // Only the two channel addresses answer.
                            d.ack = q.sh[7:1] == SLAVE_ADDR_CH0
                                 || q.sh[7:1] == SLAVE_ADDR_CH1;
                            d.chan = q.sh[7:1] == SLAVE_ADDR_CH1;
                        end
                        ST_PTR: d.ptr = q.sh;
                        ST_DATA: begin
                            d.pend = 1'b1;
                            d.pdata = q.sh;
                            d.pptr = q.ptr;
                            d.pchan = q.chan;
                        end
                        default: d.ack = 1'b0;
                    endcase
                    d.oe = d.ack;
                end else if (q.bitn == 4'h8) begin
                    d.bitn = 4'h0;
                    // A refused address, or a read byte refused by the master,
                    // frees the line so that the master can end the frame.
                    if (!q.ack || (q.phase == ST_READ && q.sda)) begin
                        d.phase = ST_IDLE;
                    end else if (q.phase == ST_ADDR) begin
                        d.phase = q.sh[0] ? ST_READ : ST_PTR;
                    end else if (q.phase == ST_PTR) begin
                        d.phase = ST_DATA;
                    end else if (q.phase == ST_DATA) begin
                        d.phase = ST_PTR;
                    end
                    if (d.phase == ST_READ) begin
                        d.sh = rd_data_i;
                        d.oe = ~rd_data_i[7];
                    end
                end else if (q.phase == ST_READ && q.bitn < 4'h7) begin
                    // The outgoing byte shifts along with the line, so its top
                    // bit is always the next one to drive.
                    d.oe = ~q.sh[7];
                end
            end
        end
        if (start && q.pend) begin
            d.pend = q.pend;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q <= '{phase: ST_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = q.oe;
    assign wr_o = q.wr;
    assign rd_ptr_o = q.ptr;
    assign rd_chan_o = q.chan;

    sequence held_byte_data_rise_s;
        $past(q.pend) && !$past(q.sda) && q.sda;
    endsequence

    AST_WRITE_AFTER_DATA_RISE: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.wr.valid |-> held_byte_data_rise_s)
        else $error("write issued without pending byte and rising data");
endmodule

// File: hdl/regbank_top.sv
`timescale 1ns/100ps
module regbank_top
    import regbank_pkg::*;
#(
    parameter logic [3:0] DEV_CODE_CH0 = 4'hA, // Arbitrary value.
    parameter logic [3:0] DEV_CODE_CH1 = 4'hB, // Arbitrary value.
    parameter logic [3:0] REV_CODE = 4'h1 // Arbitrary value.
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire regbank_pkg::chan_defaults_t [1:0] otp_i,
    output regbank_pkg::chan_out_t [1:0] chan_o
);
    import regbank_pkg::*;

    typedef struct packed {
        logic [7:0] slot1;
        logic [7:0] ceiling;
        logic [7:0] skip;
        logic [7:0] swcfg;
        logic [7:0] ramp;
        logic [7:0] target;
        logic [7:0] comp;
    } chan_regs_t;

    typedef struct packed {
        logic loaded;
        chan_regs_t [1:0] regs;
        chan_out_t [1:0] outs;
        logic [7:0] rd;
        logic sda_oe;
    } state_t;

    state_t q, d;
    wr_req_t wr;
    logic [7:0] rd_ptr;
    logic rd_chan;
    logic link_oe;
    logic link_sda;

    function automatic logic over_ceiling(input chan_regs_t r);
        return r.target > r.ceiling;
    endfunction

    function automatic logic [7:0] read_reg(input chan_regs_t r, input logic ch,
                                            input logic [7:0] ofs);
        logic [7:0] v;
        v = RST_ZERO;
        unique case (ofs)
            OFS_IDENT: v = {ch ? DEV_CODE_CH1 : DEV_CODE_CH0, REV_CODE};
            OFS_SLOT1: v = r.slot1;
            OFS_CEIL: v = r.ceiling;
            OFS_SKIP: v = r.skip;
            OFS_STATUS: v = 8'(over_ceiling(r)) << STAT_CEIL_ERR_BIT;
            OFS_SWCFG: v = r.swcfg;
            OFS_RAMP: v = r.ramp;
            OFS_TARGET: v = r.target;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction

    serial_slave u_link (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(link_sda),
        .sda_oe_o(link_oe),
        .rd_data_i(q.rd),
        .wr_o(wr),
        .rd_ptr_o(rd_ptr),
        .rd_chan_o(rd_chan)
    );

    always_comb begin
        d = q;
        d.sda_oe = link_oe;
        // Defaults are taken one cycle after reset release, never under reset.
        if (!q.loaded) begin
            d.loaded = 1'b1;
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                d.regs[c].slot1 = RST_SLOT1;
                d.regs[c].ceiling = otp_i[c].ceiling;
                d.regs[c].skip = (otp_i[c].skip & SKIP_WMASK) | RST_SKIP_LOW;
                d.regs[c].swcfg = otp_i[c].swcfg;
                d.regs[c].ramp = otp_i[c].ramp;
                d.regs[c].target = otp_i[c].target;
                d.regs[c].comp = otp_i[c].comp;
            end
        end else if (wr.valid) begin
            unique case (wr.offset)
                OFS_SLOT1: d.regs[wr.chan].slot1 = wr.data;
                OFS_CEIL: d.regs[wr.chan].ceiling = wr.data;
                OFS_SKIP: d.regs[wr.chan].skip = (wr.data & SKIP_WMASK) | RST_SKIP_LOW;
                OFS_SWCFG: d.regs[wr.chan].swcfg = wr.data;
                OFS_RAMP: d.regs[wr.chan].ramp = wr.data;
                OFS_TARGET: d.regs[wr.chan].target = wr.data;
                default: d.regs[wr.chan].slot1 = q.regs[wr.chan].slot1;
            endcase
        end
        d.rd = read_reg(q.regs[rd_chan], rd_chan, rd_ptr);
        for (int c = 0; c < NUM_CHANNELS; c++) begin
            d.outs[c].ceiling_error_flag = over_ceiling(q.regs[c]);
            // Clamping keeps the regulator inside its ceiling even while the
            // fault stands, so a bad write cannot overdrive the load.
            d.outs[c].applied_code = over_ceiling(q.regs[c]) ?
                q.regs[c].ceiling : q.regs[c].target;
            d.outs[c].skip_threshold_select = q.regs[c].skip[SKIP_SEL_LSB +: 2];
            d.outs[c].swcfg = q.regs[c].swcfg;
            d.outs[c].ramp = q.regs[c].ramp;
            d.outs[c].comp = q.regs[c].comp;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sda_o = link_sda;
    assign sda_oe_o = q.sda_oe;
    assign chan_o = q.outs;

    AST_FAULT_TRACKS_CODES: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && $past(q.loaded) |-> chan_o[0].ceiling_error_flag ==
        ($past(q.regs[0].target) > $past(q.regs[0].ceiling)))
        else $error("ceiling error flag does not follow codes");

    AST_CLAMP_APPLIED: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && $past(q.loaded) |-> chan_o[1].applied_code ==
        ($past(q.regs[1].target) > $past(q.regs[1].ceiling) ?
         $past(q.regs[1].ceiling) : $past(q.regs[1].target)))
        else $error("applied code not clamped to ceiling");

    AST_RO_WRITE_IGNORED: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && wr.valid && (wr.offset == OFS_IDENT || wr.offset == OFS_STATUS)
        |=> q.regs == $past(q.regs))
        else $error("read-only register write changed state");

    AST_WRITE_OTHER_CHAN_KEPT: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && wr.valid |=> q.regs[~$past(wr.chan)] ==
        $past(q.regs[~wr.chan]))
        else $error("write leaked into the other channel");

    AST_TARGET_WRITTEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && wr.valid && wr.offset == OFS_TARGET |=>
        q.regs[$past(wr.chan)].target == $past(wr.data))
        else $error("target write not taken");

    AST_STATUS_READ: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && rd_ptr == OFS_STATUS && $stable(rd_ptr) && $stable(rd_chan)
        && $stable(q.regs) |=> q.rd[STAT_CEIL_ERR_BIT] ==
        $past(over_ceiling(q.regs[rd_chan])))
        else $error("status ceiling bit wrong");

    AST_CEIL_WRITTEN: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded && wr.valid && wr.offset == OFS_CEIL |=>
        q.regs[$past(wr.chan)].ceiling == $past(wr.data))
        else $error("ceiling write not taken");

    AST_LOAD_ONCE: assert property (@(posedge mclk_i) disable iff (rst_i)
        q.loaded |=> q.loaded)
        else $error("default load repeated");
endmodule

// File: verification/serial_master_model.sv
`timescale 1ns/100ps
// Single bus master. SCL is driven push-pull, which a lone master may do.
// SDA is only ever pulled low, and the pull-up gives the high level.
module serial_master_model (
    input wire logic mclk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    // Clock phase length in mclk cycles; the bench raises it for a slow master.
    int hp = 4;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic half();
        repeat (hp) @(negedge mclk_i);
    endtask
    task automatic start();
        sda_oe_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_oe_o = 1'b1;
        half();
        scl_o = 1'b0;
        half();
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_oe_o = 1'b0;
        half();
    endtask
    // With hold set, SDA is pulled low just after SCL falls, so no rising
    // edge follows the slot until the master itself makes one.
    task automatic clk_bit(input logic b, input logic hold, output logic r);
        sda_oe_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_i;
        scl_o = 1'b0;
        @(negedge mclk_i);
        if (hold) begin
            sda_oe_o = 1'b1;
        end
        repeat (hp - 1) @(negedge mclk_i);
    endtask
    task automatic send(input logic [7:0] d, input logic hold, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], 1'b0, r);
        end
        clk_bit(1'b1, hold, r);
        ack = ~r;
    endtask
    task automatic recv(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, 1'b0, r);
            d[i] = r;
        end
        clk_bit(1'b1, 1'b1, r);
    endtask
endmodule

// File: verification/dual_channel_regulator_register_bank_tb.sv
`timescale 1ns/100ps
module dual_channel_regulator_register_bank_tb;
    import regbank_pkg::*;
    localparam logic [3:0] DEV0 = 4'hA; // Arbitrary value.
    localparam logic [3:0] DEV1 = 4'hB; // Arbitrary value.
    localparam logic [3:0] REV = 4'h1; // Arbitrary value.
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic scl, m_oe, sda_o, sda_oe_o, a;
    wire logic sda = (sda_oe_o ? sda_o : 1'b1) & ~m_oe;
    chan_defaults_t [1:0] otp;
    chan_out_t [1:0] chan;
    int bad_count = 0;
    int check_count = 0;
    logic [7:0] m [2][8];
    logic [7:0] w [8] = '{8'h55, 8'h5A, 8'hF0, 8'h80, 8'hFF, 8'h3C, 8'h0C, 8'h70};
    logic [7:0] e;

    regbank_top #(.DEV_CODE_CH0(DEV0), .DEV_CODE_CH1(DEV1), .REV_CODE(REV)) DUT (
        .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe_o), .otp_i(otp), .chan_o(chan));
    serial_master_model u_m (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

    always #5 mclk_i = ~mclk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [7:0] applied(input int c);
        return (m[c][7] > m[c][2]) ? m[c][2] : m[c][7];
    endfunction
    function automatic logic [6:0] sla(input logic ch);
        return ch ? SLAVE_ADDR_CH1 : SLAVE_ADDR_CH0;
    endfunction
    task automatic wr(input logic ch, input logic [7:0] ofs, input logic [7:0] d,
                      input logic fin);
        u_m.start();
        u_m.send({sla(ch), 1'b0}, 1'b0, a);
        chk({7'h00, a}, 8'h01, "write address ack");
        u_m.send(ofs, 1'b0, a);
        u_m.send(d, 1'b1, a);
        if (fin) begin
            u_m.stop();
            repeat (8) @(negedge mclk_i);
        end
        if (ofs == OFS_SKIP) begin
            m[ch][3] = (d & SKIP_WMASK) | RST_SKIP_LOW;
        end else if (ofs <= OFS_LAST && ofs != OFS_IDENT && ofs != OFS_STATUS) begin
            m[ch][ofs[2:0]] = d;
        end
        m[ch][4] = (m[ch][7] > m[ch][2]) ? (8'h01 << STAT_CEIL_ERR_BIT) : 8'h00;
    endtask
    task automatic rd(input logic ch, input logic [7:0] ofs, output logic [7:0] d);
        u_m.start();
        u_m.send({sla(ch), 1'b0}, 1'b0, a);
        u_m.send(ofs, 1'b0, a);
        u_m.start();
        u_m.send({sla(ch), 1'b1}, 1'b0, a);
        u_m.recv(d);
        u_m.stop();
    endtask
    task automatic check_all();
        logic [7:0] d;
        for (int c = 0; c < 2; c++) begin
            for (int o = 0; o < 9; o++) begin
                rd(c[0], o[7:0], d);
                chk(d, (o < 8) ? m[c][o] : 8'h00, "register read");
            end
            chk(chan[c].applied_code, applied(c), "applied code");
            chk(8'(chan[c].ceiling_error_flag), 8'(m[c][7] > m[c][2]), "fault");
            chk(8'(chan[c].skip_threshold_select), 8'(m[c][3][7:6]), "skip");
            chk(chan[c].swcfg, m[c][5], "switching config");
            chk(chan[c].ramp, m[c][6], "ramp");
            chk(chan[c].comp, otp[c].comp, "compensation");
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge mclk_i);
        bad_count++;
        $display("ERROR %0t run limit reached", $time);
        conclude();
    end

    initial begin
        otp[0] = {8'h80, 8'h40, 8'h11, 8'h05, 8'h60, 8'h9A};
        otp[1] = {8'h50, 8'hC0, 8'h22, 8'h03, 8'h70, 8'hA5};
        repeat (5) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (6) @(negedge mclk_i);
        for (int c = 0; c < 2; c++) begin
            m[c][0] = {c ? DEV1 : DEV0, REV};
            m[c][1] = RST_SLOT1;
            m[c][2] = otp[c].ceiling;
            m[c][3] = (otp[c].skip & SKIP_WMASK) | RST_SKIP_LOW;
            m[c][5] = otp[c].swcfg;
            m[c][6] = otp[c].ramp;
            m[c][7] = otp[c].target;
            m[c][4] = (m[c][7] > m[c][2]) ? (8'h01 << STAT_CEIL_ERR_BIT) : 8'h00;
        end
        check_all();
        $display("test reset values done");
        for (int o = 0; o < 8; o++) begin
            wr(1'b0, o[7:0], w[o], 1'b1);
        end
        wr(1'b1, 8'h09, 8'hEE, 1'b1);
        u_m.hp = 7;
        wr(1'b1, OFS_TARGET, 8'h40, 1'b1);
        u_m.hp = 4;
        check_all();
        $display("test writes done");
        u_m.start();
        u_m.send({7'h3A, 1'b0}, 1'b0, a);
        chk({7'h00, a}, 8'h00, "foreign address ack");
        u_m.stop();
        $display("test foreign address done");
        e = applied(0);
        wr(1'b0, OFS_TARGET, 8'hF8, 1'b0);
        repeat (20) @(negedge mclk_i);
        chk(chan[0].applied_code, e, "code before data edge");
        u_m.stop();
        repeat (8) @(negedge mclk_i);
        chk(chan[0].applied_code, 8'hF0, "code after data edge");
        chk({7'h00, chan[0].ceiling_error_flag}, 8'h01, "fault after edge");
        check_all();
        $display("test deferred load done");
        conclude();
    end
endmodule
